/* src/psec_pkg.sv */
// Purpose: Shared constants for the PHY status and error counter bank.
// Assumes: AHB-Lite register access, 10 MHz device clock.
// Notes: Register indices are word indices; byte address is index times 4.
//
// Functional notes
// - Status bit 2 reports full (1) or half duplex.
// - Status bit 1 reports 10 (1) or 100 Mb/s.
// - Status bit 0 copies link; reads never clear it.
// - Link bit is 1 while any link exists.
// - False-carrier counter, 8 bits, counts each event.
// - False-carrier counter sticks at maximum until cleared.
// - Both counters read-only, clear on read, reset zero.
// - Counter bits 15:8 ignore writes, read zero.
// - Receive-error counter counts carriers with invalid symbols.
// - At most one count per carrier event.
// - No count for a carrier with collision.
// - Receive-error counter sticks at maximum count.
// - Receive-error latch sets on event, clears on read.
// - False-carrier latch sets on event, clears on read.
package psec_pkg;

  // Register word indices.
  localparam int unsigned PSEC_IDX_W = 8;
  localparam logic [7:0] PSEC_IDX_STATUS = 8'h10;
  localparam logic [7:0] PSEC_IDX_FC = 8'h14;
  localparam logic [7:0] PSEC_IDX_RX = 8'h15;

  // Field positions in the combined status register.
  localparam int unsigned PSEC_BIT_LINK = 0;
  localparam int unsigned PSEC_BIT_SPEED = 1;
  localparam int unsigned PSEC_BIT_DUPLEX = 2;
  localparam int unsigned PSEC_BIT_FC_LATCH = 11;
  localparam int unsigned PSEC_BIT_RX_LATCH = 13;

  // Counter shape and reset values.
  localparam int unsigned PSEC_CNT_W = 8;
  localparam logic [7:0] PSEC_CNT_MAX = 8'hff;
  localparam logic [7:0] PSEC_CNT_RST = 8'h00;
  localparam logic [7:0] PSEC_CNT_ONE = 8'h01;
  localparam logic [15:0] PSEC_REG_RST = 16'h0000;
  localparam logic [31:0] PSEC_RDATA_RST = 32'h0000_0000;
  localparam logic PSEC_HRESP_OKAY = 1'b0;

  // Pin vector layout for the input synchronisers.
  localparam int unsigned PSEC_SYNC_N = 7;
  localparam int unsigned PSEC_PIN_DUPLEX = 0;
  localparam int unsigned PSEC_PIN_SPEED = 1;
  localparam int unsigned PSEC_PIN_LINK = 2;
  localparam int unsigned PSEC_PIN_FC = 3;
  localparam int unsigned PSEC_PIN_CARRIER = 4;
  localparam int unsigned PSEC_PIN_SYMERR = 5;
  localparam int unsigned PSEC_PIN_COL = 6;

  // Carrier tracking states.
  typedef enum logic [1:0] {
    PSEC_ST_IDLE = 2'b01,
    PSEC_ST_CARRIER = 2'b10
  } psec_carrier_e;

endpackage

/* src/psec_sat_counter.sv */
// Purpose: Eight-bit saturating event counter with clear on read.
// Assumes: Increment and clear are single-cycle strobes on i_clk.
// Notes: An increment in the clearing cycle leaves the count at one.
`timescale 1ns/10ps
module psec_sat_counter
  import psec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_inc,
  input wire logic i_clr,
  output logic [PSEC_CNT_W-1:0] o_count
);

  logic [PSEC_CNT_W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // Next count: clear beats hold, but an event in the same cycle survives.
  always_comb begin
    next_count = o_count;
    if (i_clr) begin
      next_count = i_inc ? PSEC_CNT_ONE : PSEC_CNT_RST;
    end else if (i_inc && (o_count != PSEC_CNT_MAX)) begin
      next_count = PSEC_CNT_W'(o_count + PSEC_CNT_ONE);
    end
  end

  // Count register.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count <= PSEC_CNT_RST;
    end else begin
      o_count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  cnt_step_a: assert property (
    i_inc && !i_clr && o_count != PSEC_CNT_MAX |=>
      o_count == PSEC_CNT_W'($past(o_count) + PSEC_CNT_ONE))
    else $error("counter did not step by one");
  cnt_sat_a: assert property (
    o_count == PSEC_CNT_MAX && !i_clr |=> o_count == PSEC_CNT_MAX)
    else $error("saturated counter moved");
  clr_inc_a: assert property (
    i_clr && i_inc |=> o_count == PSEC_CNT_ONE)
    else $error("event lost in clearing cycle");
  cnt_sat_c: cover property (o_count == PSEC_CNT_MAX && i_inc);

endmodule

/* src/psec_rx_error_event.sv */
// Purpose: Turns one carrier event into at most one receive-error pulse.
// Assumes: Inputs are already synchronised to i_clk.
// Notes: The pulse comes one cycle after carrier falls, so a collision
//   anywhere in the event can still veto it.
`timescale 1ns/10ps
module psec_rx_error_event
  import psec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_carrier,
  input wire logic i_sym_err,
  input wire logic i_collision,
  output logic o_event
);

  psec_carrier_e state, next_state;
  logic err_seen, next_err_seen;
  logic col_seen, next_col_seen;
  logic next_event;

  ////////////////////////////////////////////////////////////////////////////
  // Track errors and collisions across one carrier event.
  always_comb begin
    next_state = state;
    next_err_seen = err_seen;
    next_col_seen = col_seen;
    next_event = 1'b0;
    case (state)
      PSEC_ST_IDLE: begin
        if (i_carrier) begin
          next_state = PSEC_ST_CARRIER;
          next_err_seen = i_sym_err;
          next_col_seen = i_collision;
        end
      end
      PSEC_ST_CARRIER: begin
        if (i_carrier) begin
          next_err_seen = err_seen | i_sym_err;
          next_col_seen = col_seen | i_collision;
        end else begin
          next_state = PSEC_ST_IDLE;
          next_event = err_seen && !col_seen;
          next_err_seen = 1'b0;
          next_col_seen = 1'b0;
        end
      end
      default: begin
        next_state = PSEC_ST_IDLE;
        next_err_seen = 1'b0;
        next_col_seen = 1'b0;
      end
    endcase
  end

  // State and flag registers.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= PSEC_ST_IDLE;
      err_seen <= 1'b0;
      col_seen <= 1'b0;
      o_event <= 1'b0;
    end else begin
      state <= next_state;
      err_seen <= next_err_seen;
      col_seen <= next_col_seen;
      o_event <= next_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  ev_cause_a: assert property (
    o_event |-> $past(err_seen) && !$past(col_seen) && !$past(i_carrier))
    else $error("error pulse without clean erroneous carrier");
  ev_once_a: assert property (
    o_event |-> state == PSEC_ST_IDLE && !err_seen)
    else $error("error pulse did not end the carrier event");
  ev_col_c: cover property (state == PSEC_ST_CARRIER && i_collision);

endmodule

/* src/psec_top.sv */
// Purpose: Combined PHY status register and two clear-on-read counters.
// Assumes: AHB-Lite single word transfers; pins are asynchronous to i_clk.
// Notes: Zero wait states; writes anywhere are accepted and ignored.
//   Status bits trail their pins by two clocks of synchronisation, and
//   read data stands for exactly one cycle, the data phase of its read.
`timescale 1ns/10ps
module psec_top
  import psec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_duplex_full,
  input wire logic i_speed_10,
  input wire logic i_link_up,
  input wire logic i_false_carrier,
  input wire logic i_carrier,
  input wire logic i_symbol_err,
  input wire logic i_collision
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [PSEC_SYNC_N-1:0] pin_raw;
  logic [PSEC_SYNC_N-1:0] sync1;
  logic [PSEC_SYNC_N-1:0] sync2;
  logic duplex_s, speed_s, link_s, fc_s, carrier_s, symerr_s, col_s;
  logic fc_prev, next_fc_prev;
  logic fc_inc, rx_inc;
  logic [PSEC_CNT_W-1:0] fc_count, rx_count;
  logic fc_latch, next_fc_latch;
  logic rx_latch, next_rx_latch;
  logic [PSEC_IDX_W-1:0] idx;
  logic rd_go, rd_fc, rd_rx;
  logic [15:0] status_val;
  logic [15:0] rd_val;
  logic [31:0] next_hrdata;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers. The first stage feeds only the second, so a
  // metastable sample never reaches decode or edge logic.
  // The price is two clocks of latency on every pin; the status word and
  // both event paths all see the pins through the same delay.
  assign pin_raw = {i_collision, i_symbol_err, i_carrier, i_false_carrier,
                    i_link_up, i_speed_10, i_duplex_full};

  genvar g;
  generate
    for (g = 0; g < PSEC_SYNC_N; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  // Named views of the synchronised pins.
  assign duplex_s = sync2[PSEC_PIN_DUPLEX];
  assign speed_s = sync2[PSEC_PIN_SPEED];
  assign link_s = sync2[PSEC_PIN_LINK];
  assign fc_s = sync2[PSEC_PIN_FC];
  assign carrier_s = sync2[PSEC_PIN_CARRIER];
  assign symerr_s = sync2[PSEC_PIN_SYMERR];
  assign col_s = sync2[PSEC_PIN_COL];

  ////////////////////////////////////////////////////////////////////////////
  // False-carrier events are rising edges of the synchronised indication.
  // A pulse shorter than one clock may be missed; the source must stretch.
  // Counting edges rather than levels keeps one long false carrier from
  // being counted once per clock.
  always_comb begin
    next_fc_prev = fc_s;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fc_prev <= 1'b0;
    end else begin
      fc_prev <= next_fc_prev;
    end
  end

  assign fc_inc = fc_s && !fc_prev;

  // Receive-error events, one per clean carrier with bad symbols.
  psec_rx_error_event u_rx_event (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_carrier(carrier_s),
    .i_sym_err(symerr_s),
    .i_collision(col_s),
    .o_event(rx_inc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Reads clear at the address phase so the captured value is
  // exactly what was cleared; nothing counted after it is lost.
  // Only the word index is decoded; size and byte lanes are not checked,
  // so a narrow read still clears the whole counter. Decoding is gated
  // with hready so a stalled bus never clears a counter twice.
  assign idx = i_haddr[PSEC_IDX_W+1:2];
  assign rd_go = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  assign rd_fc = rd_go && (idx == PSEC_IDX_FC);
  assign rd_rx = rd_go && (idx == PSEC_IDX_RX);

  // Event counters.
  psec_sat_counter u_fc_count (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_inc(fc_inc),
    .i_clr(rd_fc),
    .o_count(fc_count)
  );

  psec_sat_counter u_rx_count (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_inc(rx_inc),
    .i_clr(rd_rx),
    .o_count(rx_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Latch bits: the set wins over a clearing read in the same cycle.
  // An event that lands in the clearing cycle is thus still flagged after
  // the read, matching the counter, which restarts at one.
  always_comb begin
    next_fc_latch = fc_latch;
    next_rx_latch = rx_latch;
    if (rd_fc) begin
      next_fc_latch = 1'b0;
    end
    if (fc_inc) begin
      next_fc_latch = 1'b1;
    end
    if (rd_rx) begin
      next_rx_latch = 1'b0;
    end
    if (rx_inc) begin
      next_rx_latch = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fc_latch <= 1'b0;
      rx_latch <= 1'b0;
    end else begin
      fc_latch <= next_fc_latch;
      rx_latch <= next_rx_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined status word; reading it clears nothing.
  always_comb begin
    status_val = PSEC_REG_RST;
    status_val[PSEC_BIT_DUPLEX] = duplex_s;
    status_val[PSEC_BIT_SPEED] = speed_s;
    status_val[PSEC_BIT_LINK] = link_s;
    status_val[PSEC_BIT_FC_LATCH] = fc_latch;
    status_val[PSEC_BIT_RX_LATCH] = rx_latch;
  end

  // Read mux; counters sit in the low byte, upper bits are zero.
  always_comb begin
    rd_val = PSEC_REG_RST;
    case (idx)
      PSEC_IDX_STATUS: rd_val = status_val;
      PSEC_IDX_FC: rd_val = {8'h00, fc_count};
      PSEC_IDX_RX: rd_val = {8'h00, rx_count};
      default: rd_val = PSEC_REG_RST;
    endcase
    next_hrdata = rd_go ? {16'h0000, rd_val} : PSEC_RDATA_RST;
  end

  // Bus outputs, all registered. Always ready, always OKAY; writes are
  // dropped because every register here is read-only.
  // Ready is held low in reset so no transfer can start before the
  // counters and latches have left their reset state.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hrdata <= PSEC_RDATA_RST;
      o_hreadyout <= 1'b0;
      o_hresp <= PSEC_HRESP_OKAY;
    end else begin
      o_hrdata <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp <= PSEC_HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Each read check looks one clock after the address phase, at the edge where
  // the master takes the data.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  status_bits_a: assert property (
    rd_go && idx == PSEC_IDX_STATUS |=>
      o_hrdata[2:0] == {$past(duplex_s), $past(speed_s), $past(link_s)})
    else $error("status low bits do not follow pins");
  link_keep_a: assert property (
    (rd_go && idx == PSEC_IDX_STATUS && link_s) ##2
      (rd_go && idx == PSEC_IDX_STATUS && link_s) |=>
      o_hrdata[PSEC_BIT_LINK])
    else $error("status read disturbed the link bit");
  cnt_read_a: assert property (
    rd_fc |=> o_hrdata == {24'h000000, $past(fc_count)})
    else $error("false-carrier read data wrong");
  rx_read_a: assert property (
    rd_rx |=> o_hrdata == {24'h000000, $past(rx_count)})
    else $error("receive-error read data wrong");
  fc_clear_a: assert property (
    rd_fc && !fc_inc |=> fc_count == PSEC_CNT_RST)
    else $error("false-carrier counter not cleared by read");
  fc_latch_a: assert property (
    fc_inc |=> fc_latch ##0 fc_count != PSEC_CNT_RST)
    else $error("false-carrier latch missed an event");
  rx_latch_a: assert property (
    rx_inc |=> rx_latch)
    else $error("receive-error latch missed an event");
  latch_clear_a: assert property (
    rd_rx && !rx_inc |=> !rx_latch)
    else $error("receive-error latch not cleared by read");
  fc_latch_clr_a: assert property (
    rd_fc && !fc_inc |=> !fc_latch)
    else $error("false-carrier latch not cleared by read");
  rx_clear_a: assert property (
    rd_rx && !rx_inc |=> rx_count == PSEC_CNT_RST)
    else $error("receive-error counter not cleared by read");
  rx_count_a: assert property (
    rx_inc |=> rx_count != PSEC_CNT_RST)
    else $error("receive-error event was not counted");
  fc_once_a: assert property (
    fc_inc |=> !fc_inc)
    else $error("one false carrier counted twice");
  rx_keep_a: assert property (
    rx_latch && !rd_rx |=> rx_latch)
    else $error("receive-error latch dropped without a read");
  fc_keep_a: assert property (
    fc_latch && !rd_fc |=> fc_latch)
    else $error("false-carrier latch dropped without a read");
  status_latch_a: assert property (
    rd_go && idx == PSEC_IDX_STATUS |=>
      o_hrdata[PSEC_BIT_FC_LATCH] == $past(fc_latch) &&
      o_hrdata[PSEC_BIT_RX_LATCH] == $past(rx_latch))
    else $error("status latch bits do not show the latches");

  // A clearing read and an event in one cycle: the latch stays set and the
  // counter restarts at one, so software sees the event on its next read.
  fc_race_a: assert property (
    rd_fc && fc_inc |=> fc_latch && fc_count == PSEC_CNT_ONE)
    else $error("false-carrier event lost against a read");
  rx_race_a: assert property (
    rd_rx && rx_inc |=> rx_latch && rx_count == PSEC_CNT_ONE)
    else $error("receive-error event lost against a read");

  // Writes land nowhere: every register here is read-only, so a write must
  // leave both counters where a write-free cycle would have left them.
  wr_fc_a: assert property (
    i_hsel && i_htrans[1] && i_hready && i_hwrite && !fc_inc |=>
      $stable(fc_count))
    else $error("write disturbed the false-carrier counter");
  wr_rx_a: assert property (
    i_hsel && i_htrans[1] && i_hready && i_hwrite && !rx_inc |=>
      $stable(rx_count))
    else $error("write disturbed the receive-error counter");

  // Outside a read's data phase the bus shows zeros, and so does a read of
  // a word that holds no register or a status bit this block leaves out.
  idle_data_a: assert property (
    !rd_go |=> o_hrdata == PSEC_RDATA_RST)
    else $error("read data driven outside a read");
  unmapped_a: assert property (
    rd_go && idx != PSEC_IDX_STATUS && idx != PSEC_IDX_FC &&
      idx != PSEC_IDX_RX |=> o_hrdata == PSEC_RDATA_RST)
    else $error("unmapped word did not read zero");
  status_rsvd_a: assert property (
    rd_go && idx == PSEC_IDX_STATUS |=>
      o_hrdata[31:14] == 18'h00000 && !o_hrdata[12] &&
      o_hrdata[10:3] == 8'h00)
    else $error("status bits outside the block read nonzero");

  // The slave never stalls and never errors once it is out of reset.
  okay_a: assert property (
    o_hresp == PSEC_HRESP_OKAY)
    else $error("slave gave a response other than okay");
  ready_a: assert property (
    $past(i_arst_n) |-> o_hreadyout)
    else $error("bus not ready after reset");

  read_fc_c: cover property (rd_fc && fc_count != PSEC_CNT_RST);
  clr_race_c: cover property (rd_rx && rx_inc);
  status_c: cover property (rd_go && idx == PSEC_IDX_STATUS && link_s);

endmodule

/* tb/psec_tb_top.sv */
// Purpose: Self-checking bench for the PHY status and error counter bank.
// Assumes: AHB-Lite slave of any wait; pins pass two synchronising flops.
// Notes: Event waits are fixed spans longer than the stated pin latency.
`timescale 1ns/10ps
module psec_tb_top;
  import psec_pkg::*;

  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic duplex = 1'b0;
  logic speed = 1'b0;
  logic link = 1'b0;
  logic fc = 1'b0;
  logic carrier = 1'b0;
  logic symerr = 1'b0;
  logic col = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  logic [31:0] d0;
  logic [31:0] d1;

  // Clock at 10 MHz.
  always #50 i_clk = ~i_clk;

  psec_top i_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_duplex_full(duplex),
    .i_speed_10(speed), .i_link_up(link), .i_false_carrier(fc),
    .i_carrier(carrier), .i_symbol_err(symerr), .i_collision(col)
  );

  //////////////////////////////////////////////////////////////////////////
  // Closing, comparison and bus tasks.

  task automatic end_of_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Ready and data are taken at the rising edge, before its updates land.
  task automatic wait_rdy(output logic [31:0] d);
    @(posedge i_clk);
    while (hready !== 1'b1) begin
      @(posedge i_clk);
    end
    d = hrdata;
  endtask

  // One single-word transfer; entered and left just after a rising edge.
  task automatic xfer(input logic [31:0] a, input logic wr,
                      input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(d);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy(d);
    chk({31'h0, hresp}, {31'h0, PSEC_HRESP_OKAY});
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    xfer(a, 1'b0, 32'h0, d);
    chk(d, exp);
  endtask

  // One false carrier: high three cycles, low three cycles.
  task automatic fc_pulse();
    fc <= 1'b1;
    cyc(3);
    fc <= 1'b0;
    cyc(3);
  endtask

  // One carrier event with nb error bursts, optionally with collision.
  task automatic rx_evt(input int nb, input logic c);
    carrier <= 1'b1;
    for (int i = 0; i < nb; i++) begin
      cyc(2);
      symerr <= 1'b1;
      col <= c;
      cyc(2);
      symerr <= 1'b0;
      col <= 1'b0;
    end
    cyc(2);
    carrier <= 1'b0;
    cyc(6);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Watchdog, sized well above the few thousand cycles the tests need.
  initial begin
    cyc(20000);
    n_fail++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    cyc(4);
    i_arst_n <= 1'b1;
    cyc(2);
    // Reset values and an unmapped word.
    rdc(32'h40, 32'h0);
    rdc(32'h50, 32'h0);
    rdc(32'h54, 32'h0);
    rdc(32'h44, 32'h0);
    // Every pin combination shows, and reading status clears nothing.
    for (int k = 0; k < 8; k++) begin
      {duplex, speed, link} <= k[2:0];
      cyc(4);
      rdc(32'h40, {29'h0, k[2:0]});
      rdc(32'h40, {29'h0, k[2:0]});
    end
    // Duplex and speed are only trusted with link up, as software must.
    {duplex, speed, link} <= 3'h5;
    cyc(4);
    rdc(32'h40, 32'h5);
    {duplex, speed, link} <= 3'h0;
    cyc(4);
    // Three false carriers, a write that must not land, then clear on read.
    repeat (3) fc_pulse();
    cyc(4);
    rdc(32'h40, 32'h800);
    xfer(32'h50, 1'b1, 32'hffff_ffff, d0);
    rdc(32'h50, 32'h3);
    rdc(32'h50, 32'h0);
    rdc(32'h40, 32'h0);
    // Saturation after one event too many.
    repeat (256) fc_pulse();
    cyc(4);
    rdc(32'h50, 32'hff);
    rdc(32'h50, 32'h0);
    // An event near a clearing read is counted exactly once.
    for (int k = 0; k < 5; k++) begin
      fc <= 1'b1;
      cyc(k);
      xfer(32'h50, 1'b0, 32'h0, d0);
      fc <= 1'b0;
      cyc(8);
      xfer(32'h50, 1'b0, 32'h0, d1);
      chk(d0 + d1, 32'h1);
    end
    rdc(32'h40, 32'h0);
    // Receive errors: clean carrier, one burst, two bursts, collision.
    rx_evt(0, 1'b0);
    rdc(32'h40, 32'h0);
    rx_evt(1, 1'b0);
    rx_evt(2, 1'b0);
    rx_evt(1, 1'b1);
    rdc(32'h40, 32'h2000);
    xfer(32'h54, 1'b1, 32'hffff_ffff, d0);
    rdc(32'h54, 32'h2);
    rdc(32'h54, 32'h0);
    rdc(32'h40, 32'h0);
    // Receive-error counter sticks at its maximum.
    repeat (256) rx_evt(1, 1'b0);
    rdc(32'h54, 32'hff);
    rdc(32'h54, 32'h0);
    end_of_test();
  end
endmodule
